//--- pkg/pirc_pkg.sv
// Purpose: Shared constants and carrier types for the port interrupt and reset control block.
// Assumes: Classic Wishbone with 32-bit data; every register uses the low byte of its word.
// Notes:   Offsets are byte addresses, and each channel block repeats at a fixed stride.
package pirc_pkg;

    localparam int          ADR_W        = 8;
    localparam logic [7:0]  CH_STRIDE    = 8'h10;
    localparam logic [7:0]  OFS_IER      = 8'h00;
    localparam logic [7:0]  OFS_MODEM    = 8'h04;
    localparam logic [7:0]  OFS_LSR      = 8'h08;
    localparam logic [7:0]  OFS_SVC      = 8'h0c;
    localparam logic [7:0]  OFS_RUN      = 8'h20;
    localparam logic [7:0]  OFS_PWDATA   = 8'h24;
    localparam logic [7:0]  OFS_PWCTRL   = 8'h28;
    localparam logic [7:0]  OFS_PSTAT    = 8'h2c;
    localparam logic [7:0]  OFS_PRDATA   = 8'h30;

    localparam logic [7:0]  LSR_RST      = 8'h60;
    localparam logic [7:0]  BYTE_RST     = 8'h00;
    localparam int          LSR_TX_HOLDING_EMPTY_FLAG_BIT = 5;
    localparam int          MODEM_DTR    = 0;
    localparam int          MODEM_RTS    = 1;
    localparam int          MODEM_OUT1   = 2;
    localparam int          MODEM_IRQEN  = 3;
    localparam int          MODEM_LOOP   = 4;
    localparam int          PW_IRQEN     = 4;
    localparam int          PW_DIR       = 5;
    localparam int          SVC_TX_HOLDING_EMPTY_FLAG     = 1;
    localparam int          N_CH         = 2;
    localparam int          PIN_W        = 12;

    typedef struct packed {
        logic              cyc;
        logic              stb;
        logic              we;
        logic [ADR_W-1:0]  adr;
        logic [3:0]        sel;
        logic [31:0]       dat;
    } pirc_wb_req_t;

endpackage

//--- verilog/pirc_sync2.sv
// Purpose: Two flip-flop synchroniser for pin inputs.
// Assumes: Each bit is an independent level; no bus coherence is needed.
// Notes:   The first stage is read only by the second stage.
`timescale 1ns/1ps
module pirc_sync2 #(
    parameter int W = 1
) (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] meta_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            meta_r <= '0;
            q      <= '0;
        end else begin
            meta_r <= d;
            q      <= meta_r;
        end
    end
endmodule

//--- verilog/pirc_top.sv
// Purpose: Serial and printer interrupt outputs, reset state and parallel port direction.
// Assumes: Pins except print_flag_in pass a two-flop synchroniser; channel status inputs come from logic on clk.
// Notes:   Three-state pins are split into value and active-low enable.
// Notes on behaviour
// RL1: Serial interrupt pin is driven only while modem control bit 3 is set.
// RL2: Serial interrupt goes high when any enabled channel condition is active.
// RL3: Serial interrupt holds until the host services its source; the code holds only the holding-empty source, the others follow their inputs.
// RL4: Serial interrupt pins float while reset is applied.
// RL5: Printer interrupt is active high and set on a rising acknowledge edge.
// RL6: Printer interrupt pin is driven only while write control bit 4 is set.
// RL7: Printer interrupt pin floats on reset.
// RL8: Eight parallel data lines form a byte port usable in both directions.
// RL9: The printer drives media empty high when out of paper.
// RL10: With enhanced select low the write data always drives the data lines; the code releases them while reset is applied.
// RL11: With enhanced select high the direction bit steers the data lines.
// RL12: Boards normally tie enhanced select low for a plain printer.
// RL13: Reset suspends all serial receive and transmit activity.
// RL14: Reset clears modem control and returns every modem output inactive.
// RL15: Reset clears line status except both transmitter empty flags, which set.
// RL16: After reset the channels stay idle until the host enables them again.
// RL17: Source select low follows acknowledge; high follows the printer status flag.
// RL18: Terminal ready outputs go high, inactive, on reset.
// RL19: Request to send outputs go high, inactive, on reset.
// RL20: Transmit lines sit at mark level while reset is applied.
// RL21: An enabled serial interrupt pin with nothing pending is driven low.
`timescale 1ns/1ps
module pirc_top
    import pirc_pkg::*;
(
    input  wire logic                  clk,
    input  wire logic                  rst,
    input  wire pirc_wb_req_t          wb_req,
    output logic                       wb_ack,
    output logic [31:0]                wb_dat_o,
    input  wire logic [N_CH-1:0][7:0]  line_status_in,
    input  wire logic [N_CH-1:0]       modem_delta_in,
    input  wire logic [N_CH-1:0]       tx_data_in,
    output logic [N_CH-1:0]            serial_tx_lines,
    output logic [N_CH-1:0]            serial_active,
    output logic [N_CH-1:0]            dtr_n,
    output logic [N_CH-1:0]            rts_n,
    output logic [N_CH-1:0]            out1_n,
    output logic [N_CH-1:0]            loop_mode,
    output logic [N_CH-1:0]            serial_irq_outputs,
    output logic [N_CH-1:0]            serial_irq_oe_n,
    output logic                       printer_irq_output,
    output logic                       printer_irq_oe_n,
    input  wire logic                  ack_pin,
    input  wire logic                  media_empty_input,
    input  wire logic                  enhanced_port_select,
    input  wire logic                  printer_irq_source_select,
    input  wire logic                  print_flag_in,
    input  wire logic [7:0]            parallel_data_lines_i,
    output logic [7:0]                 parallel_data_lines_o,
    output logic                       parallel_data_lines_oe_n
);

    // Synchronised pins.
    logic [PIN_W-1:0] pins_s;
    logic [7:0]       pd_s;
    logic             ack_s;
    logic             media_s;
    logic             enh_s;
    logic             src_s;

    // Software state.
    logic [N_CH-1:0][3:0] irq_enable_r;
    logic [N_CH-1:0][4:0] modem_control_reg_r;
    logic [N_CH-1:0][7:0] line_status_r;
    logic [N_CH-1:0]      run_r;
    logic [7:0]           pw_data_r;
    logic [7:0]           pw_ctrl_r;

    // Hardware state.
    logic [N_CH-1:0]      tx_holding_empty_flag_prev_r;
    logic [N_CH-1:0]      tx_holding_empty_flag_pend_r;
    logic [N_CH-1:0]      serial_irq_r;
    logic                 ack_prev_r;
    logic                 prt_latch_r;
    logic                 prt_irq_r;
    logic                 ack_r;
    logic [31:0]          rdata_r;

    // Decode.
    logic                 req;
    logic                 wr_now;
    logic                 rd_now;
    logic [7:0]           wbyte;
    logic                 pd_drive;
    logic [N_CH-1:0][3:0] cond;

    pirc_sync2 #(
        .W (PIN_W)
    ) u_sync (
        .clk (clk),
        .rst (rst),
        .d   ({src_pin_cat(printer_irq_source_select, enhanced_port_select, media_empty_input, ack_pin),
                parallel_data_lines_i}),
        .q   (pins_s)
    );

    function automatic logic [3:0] src_pin_cat(input logic a, input logic b, input logic c, input logic d);
        src_pin_cat = {a, b, c, d};
    endfunction

    assign pd_s    = pins_s[7:0];
    assign ack_s   = pins_s[8];
    assign media_s = pins_s[9];
    assign enh_s   = pins_s[10];
    assign src_s   = pins_s[11];

    // True when the address hits the given register of the given channel.
    function automatic logic ch_hit(input logic [ADR_W-1:0] a, input int ch, input logic [7:0] ofs);
        ch_hit = (a == 8'(ch * 16) + ofs);
    endfunction

    // The write and its side effects land on the edge at which the master sees ack.
    assign req    = wb_req.cyc && wb_req.stb;
    assign wr_now = req && wb_req.we && ack_r && wb_req.sel[0];
    assign rd_now = req && !wb_req.we && ack_r;
    assign wbyte  = wb_req.dat[7:0];

    // One wait cycle keeps the read mux off the combinational path to the master.
    always_ff @(posedge clk) begin
        if (rst) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req && !ack_r;
        end
    end
    assign wb_ack = ack_r;

    always_ff @(posedge clk) begin
        if (rst) begin
            rdata_r <= 32'h0000_0000;
        end else if (req && !ack_r) begin
            rdata_r <= 32'h0000_0000;
            for (int c = 0; c < N_CH; c++) begin
                if (ch_hit(wb_req.adr, c, OFS_IER)) begin
                    rdata_r[3:0] <= irq_enable_r[c];
                end
                if (ch_hit(wb_req.adr, c, OFS_MODEM)) begin
                    rdata_r[4:0] <= modem_control_reg_r[c];
                end
                if (ch_hit(wb_req.adr, c, OFS_LSR)) begin
                    rdata_r[7:0] <= line_status_r[c];
                end
                if (ch_hit(wb_req.adr, c, OFS_SVC)) begin
                    rdata_r[4:0] <= {serial_irq_r[c], cond[c]};
                end
            end
            unique case (wb_req.adr)
                OFS_RUN:    rdata_r[N_CH-1:0] <= run_r;
                OFS_PWDATA: rdata_r[7:0] <= pw_data_r;
                OFS_PWCTRL: rdata_r[7:0] <= pw_ctrl_r;
                OFS_PSTAT:  rdata_r[6:0] <= {pd_drive, src_s, enh_s, prt_latch_r, print_flag_in, media_s, ack_s};
                OFS_PRDATA: rdata_r[7:0] <= pd_s;
                default:    ;
            endcase
        end
    end
    assign wb_dat_o = rdata_r;

    // Per-channel control and status.
    always_ff @(posedge clk) begin
        for (int c = 0; c < N_CH; c++) begin
            if (rst) begin
                irq_enable_r[c]        <= 4'h0;
                modem_control_reg_r[c] <= 5'h00;                    // [RL14]
                line_status_r[c]       <= LSR_RST;                  // [RL15]
                run_r[c]               <= 1'b0;                     // [RL13] [RL16]
            end else begin
                line_status_r[c] <= line_status_in[c];
                if (wr_now && ch_hit(wb_req.adr, c, OFS_IER)) begin
                    irq_enable_r[c] <= wbyte[3:0];
                end
                if (wr_now && ch_hit(wb_req.adr, c, OFS_MODEM)) begin
                    modem_control_reg_r[c] <= wbyte[4:0];
                end
                if (wr_now && wb_req.adr == OFS_RUN) begin
                    run_r[c] <= wbyte[c];                           // [RL16]
                end
            end
        end
    end

    // The holding-empty condition is sticky so a host that misses the edge still sees it.
    always_ff @(posedge clk) begin
        for (int c = 0; c < N_CH; c++) begin
            if (rst) begin
                tx_holding_empty_flag_prev_r[c] <= 1'b1;
                tx_holding_empty_flag_pend_r[c] <= 1'b0;
            end else begin
                tx_holding_empty_flag_prev_r[c] <= line_status_r[c][LSR_TX_HOLDING_EMPTY_FLAG_BIT];
                if (line_status_r[c][LSR_TX_HOLDING_EMPTY_FLAG_BIT] && !tx_holding_empty_flag_prev_r[c]) begin
                    tx_holding_empty_flag_pend_r[c] <= 1'b1;                         // [RL3]
                end else if (wr_now && ch_hit(wb_req.adr, c, OFS_SVC) && wbyte[SVC_TX_HOLDING_EMPTY_FLAG]) begin
                    tx_holding_empty_flag_pend_r[c] <= 1'b0;                         // [RL3]
                end
            end
        end
    end

    always_comb begin
        for (int c = 0; c < N_CH; c++) begin
            cond[c] = {modem_delta_in[c], |line_status_r[c][4:1], tx_holding_empty_flag_pend_r[c], line_status_r[c][0]};
        end
    end

    always_ff @(posedge clk) begin
        for (int c = 0; c < N_CH; c++) begin
            if (rst) begin
                serial_irq_r[c] <= 1'b0;
            end else begin
                serial_irq_r[c] <= |(irq_enable_r[c] & cond[c]);   // [RL2] [RL21]
            end
        end
    end

    always_comb begin
        for (int c = 0; c < N_CH; c++) begin
            serial_irq_outputs[c] = serial_irq_r[c];
            serial_irq_oe_n[c]    = rst || !modem_control_reg_r[c][MODEM_IRQEN]; // [RL1] [RL4]
            dtr_n[c]              = !modem_control_reg_r[c][MODEM_DTR];  // [RL18]
            rts_n[c]              = !modem_control_reg_r[c][MODEM_RTS];  // [RL19]
            out1_n[c]             = !modem_control_reg_r[c][MODEM_OUT1]; // [RL14]
            loop_mode[c]          = modem_control_reg_r[c][MODEM_LOOP];
            serial_active[c]      = run_r[c] && !rst;                    // [RL13]
            serial_tx_lines[c]    = (rst || !run_r[c] || loop_mode[c]) ? 1'b1 : tx_data_in[c]; // [RL20]
        end
    end

    // Printer port registers.
    always_ff @(posedge clk) begin
        if (rst) begin
            pw_data_r <= BYTE_RST;
            pw_ctrl_r <= BYTE_RST;
        end else begin
            if (wr_now && wb_req.adr == OFS_PWDATA) begin
                pw_data_r <= wbyte;
            end
            if (wr_now && wb_req.adr == OFS_PWCTRL) begin
                pw_ctrl_r <= wbyte;
            end
        end
    end

    // The latch keeps a short acknowledge pulse visible until the status register is read.
    always_ff @(posedge clk) begin
        if (rst) begin
            ack_prev_r  <= 1'b0;
            prt_latch_r <= 1'b0;
        end else begin
            ack_prev_r <= ack_s;
            if (ack_s && !ack_prev_r) begin
                prt_latch_r <= 1'b1;                                // [RL5]
            end else if (rd_now && wb_req.adr == OFS_PSTAT) begin
                prt_latch_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            prt_irq_r <= 1'b0;
        end else begin
            prt_irq_r <= src_s ? print_flag_in : prt_latch_r;      // [RL17]
        end
    end

    assign printer_irq_output = prt_irq_r;
    assign printer_irq_oe_n   = rst || !pw_ctrl_r[PW_IRQEN];        // [RL6] [RL7]

    // A high direction bit turns the port around only in enhanced mode.
    assign pd_drive                 = !enh_s || !pw_ctrl_r[PW_DIR]; // [RL8] [RL10] [RL11] [RL12]
    assign parallel_data_lines_o    = pw_data_r;                    // [RL10]
    assign parallel_data_lines_oe_n = rst || !pd_drive;             // [RL8]

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    chk_sirq_enable_gate: assert property ( // [RL1]
        modem_control_reg_r[0][MODEM_IRQEN] != serial_irq_oe_n[0])
        else $error("Serial interrupt enable does not follow modem control bit.");

    chk_sirq_rise_cause: assert property ( // [RL2]
        $rose(serial_irq_outputs[0]) |-> $past(|(irq_enable_r[0] & cond[0])))
        else $error("Serial interrupt rose without an enabled condition.");

    chk_sirq_follows_cond: assert property ( // [RL2]
        (|(irq_enable_r[1] & cond[1])) |=> serial_irq_outputs[1])
        else $error("Enabled condition did not raise serial interrupt.");

    chk_tx_holding_empty_flag_hold: assert property ( // [RL3]
        tx_holding_empty_flag_pend_r[0] && !(wr_now && ch_hit(wb_req.adr, 0, OFS_SVC)) |=> tx_holding_empty_flag_pend_r[0])
        else $error("Holding-empty pending dropped without service.");

    chk_prt_ack_latch: assert property ( // [RL5]
        (ack_s && !ack_prev_r) |=> prt_latch_r)
        else $error("Acknowledge rise did not latch printer interrupt.");

    chk_prt_src_follow: assert property ( // [RL17]
        src_s && $stable(src_s) |=> printer_irq_output == $past(print_flag_in))
        else $error("Printer interrupt did not follow status flag.");

    chk_prt_enable_gate: assert property ( // [RL6]
        printer_irq_oe_n == !pw_ctrl_r[PW_IRQEN])
        else $error("Printer interrupt enable does not follow control bit.");

    chk_pd_plain_drive: assert property ( // [RL10]
        !enh_s |-> !parallel_data_lines_oe_n && parallel_data_lines_o == pw_data_r)
        else $error("Plain mode does not drive write data.");

    chk_pd_dir_input: assert property ( // [RL11]
        enh_s && pw_ctrl_r[PW_DIR] |-> parallel_data_lines_oe_n)
        else $error("Enhanced input direction still drives data lines.");

    chk_idle_after_rst: assert property ( // [RL16] [RL20]
        $fell(rst) |-> (!serial_active[0] && serial_tx_lines == 2'h3) [*2])
        else $error("Channel left idle without host programming.");

    chk_modem_clear_rst: assert property (@(posedge clk) disable iff (1'b0) // [RL14] [RL18] [RL19]
        $past(rst) |-> dtr_n == 2'h3 && rts_n == 2'h3 && line_status_r[1] == LSR_RST)
        else $error("Reset did not clear modem state.");

endmodule

//--- bench/pirc_prt_model.sv
// Purpose: Printer model on the far side of the parallel port.
// Assumes: The bench commands it on clk.
// Notes:   Released data lines show pdata while drive is set, else the inverse of the last value, so a stale read cannot pass.
`timescale 1ns/1ps
module pirc_prt_model (
    input  wire logic       clk,
    input  wire logic       ack_go,
    input  wire logic       paper_out,
    input  wire logic       drive,
    input  wire logic [7:0] pdata,
    input  wire logic [7:0] pd_o,
    input  wire logic       pd_oe_n,
    output logic            ack_pin,
    output logic            media_empty,
    output logic [7:0]      pd
);
    logic [2:0] ack_cnt_r = 3'h0;
    logic [7:0] last_r    = 8'h00;
    always_ff @(posedge clk) begin
        if (ack_go) begin
            ack_cnt_r <= 3'h5;
        end else if (ack_cnt_r != 3'h0) begin
            ack_cnt_r <= ack_cnt_r - 3'h1;
        end
    end
    always_ff @(posedge clk) begin
        last_r <= pd;
    end
    assign ack_pin     = (ack_cnt_r != 3'h0);
    assign media_empty = paper_out;
    assign pd          = !pd_oe_n ? pd_o : (drive ? pdata : ~last_r);
endmodule

//--- bench/tb_top.sv
// Purpose: Self-checking bench for the port interrupt and reset control block.
// Assumes: Classic Wishbone, one register per word, low byte only.
// Notes:   Outputs are sampled on the falling edge so flop updates have landed.
`timescale 1ns/1ps
module tb_top
    import pirc_pkg::*;
;
    logic                 clk, rst, wb_ack, ack_pin, media_empty_input, enhanced_port_select;
    logic                 printer_irq_source_select, print_flag_in, printer_irq_output, printer_irq_oe_n;
    pirc_wb_req_t         wb_req;
    logic [31:0]          wb_dat_o, rd, lfsr;
    logic [N_CH-1:0][7:0] line_status_in;
    logic [1:0]           modem_delta_in, tx_data_in, serial_tx_lines, serial_active, dtr_n, rts_n;
    logic [1:0]           out1_n, loop_mode, serial_irq_outputs, serial_irq_oe_n;
    logic [7:0]           pd, pd_o, pdata, v;
    logic                 pd_oe_n, ack_go, paper_out, drive;
    int                   n_mismatch, checks, cycles;
    pirc_top pirc_top_inst (.clk(clk), .rst(rst), .wb_req(wb_req), .wb_ack(wb_ack), .wb_dat_o(wb_dat_o),
        .line_status_in(line_status_in), .modem_delta_in(modem_delta_in), .tx_data_in(tx_data_in),
        .serial_tx_lines(serial_tx_lines), .serial_active(serial_active), .dtr_n(dtr_n), .rts_n(rts_n),
        .out1_n(out1_n), .loop_mode(loop_mode), .serial_irq_outputs(serial_irq_outputs),
        .serial_irq_oe_n(serial_irq_oe_n), .printer_irq_output(printer_irq_output),
        .printer_irq_oe_n(printer_irq_oe_n), .ack_pin(ack_pin), .media_empty_input(media_empty_input),
        .enhanced_port_select(enhanced_port_select), .printer_irq_source_select(printer_irq_source_select),
        .print_flag_in(print_flag_in), .parallel_data_lines_i(pd), .parallel_data_lines_o(pd_o),
        .parallel_data_lines_oe_n(pd_oe_n));
    pirc_prt_model pirc_prt_model_inst (.clk(clk), .ack_go(ack_go), .paper_out(paper_out), .drive(drive),
        .pdata(pdata), .pd_o(pd_o), .pd_oe_n(pd_oe_n), .ack_pin(ack_pin), .media_empty(media_empty_input),
        .pd(pd));
    function automatic logic [31:0] nxt(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    task automatic end_sim();
        if (n_mismatch == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        wb_req <= '{1'b1, 1'b1, we, a, 4'hf, d};
        @(posedge clk);
        while (wb_ack !== 1'b1) begin
            @(posedge clk);
        end
        rd = wb_dat_o;
        wb_req <= '0;
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask
    task automatic setc(input int c, input int k, input logic on);
        @(posedge clk);
        case (k)
            0: line_status_in[c][0] <= on;
            1: line_status_in[c][5] <= on;
            2: line_status_in[c][1 + lfsr[1:0]] <= on;
            default: modem_delta_in[c] <= on;
        endcase
    endtask
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles > 20000) begin
            n_mismatch++;
            end_sim();
        end
    end
    initial begin
        {rst, lfsr} = {1'b1, 32'd69207};
        {wb_req, modem_delta_in, tx_data_in, ack_go, paper_out, drive, pdata, print_flag_in} = '0;
        line_status_in = {2{8'h60}};
        printer_irq_source_select = 1'b0;
        enhanced_port_select = 1'b0;
        settle(5);
        chk("irq_oe_rst", 7, {printer_irq_oe_n, serial_irq_oe_n});
        chk("tx_rst", 3, serial_tx_lines);
        chk("act_rst", 0, serial_active);
        chk("dtr_rts_rst", 4'hf, {dtr_n, rts_n});
        @(posedge clk);
        rst <= 1'b0;
        settle(3);
        chk("idle", 5'h06, {serial_active, serial_tx_lines, pd_oe_n});
        wb(1'b0, OFS_LSR, 0);
        chk("lsr", LSR_RST, rd);
        line_status_in <= '0;
        for (int c = 0; c < N_CH; c++) begin
            lfsr = nxt(lfsr);
            v = {3'h0, lfsr[4:0]};
            wb(1'b1, 8'(c * 16 + OFS_MODEM), v);
            settle(1);
            chk("modem", {v[4], ~v[2:0], ~v[3]}, {loop_mode[c], out1_n[c], rts_n[c], dtr_n[c], serial_irq_oe_n[c]});
        end
        @(posedge clk);
        rst <= 1'b1;
        settle(3);
        chk("modem_rst", 8'hff, {dtr_n, rts_n, out1_n, serial_irq_oe_n});
        @(posedge clk);
        rst <= 1'b0;
        for (int c = 0; c < N_CH; c++) begin
            wb(1'b1, 8'(c * 16 + OFS_MODEM), 8'h08);
            for (int k = 0; k < 4; k++) begin
                lfsr = nxt(lfsr);
                wb(1'b1, 8'(c * 16 + OFS_IER), 0);
                setc(c, k, 1'b1);
                settle(4);
                chk("irq_masked", 0, serial_irq_outputs[c]);
                wb(1'b1, 8'(c * 16 + OFS_IER), 1 << k);
                settle(3);
                chk("irq_set", 1, {serial_irq_oe_n[c], serial_irq_outputs[c]});
                setc(c, k, 1'b0);
                settle(4);
                if (k == 1) begin
                    chk("irq_hold", 1, serial_irq_outputs[c]);
                    wb(1'b1, 8'(c * 16 + OFS_SVC), 1 << SVC_TX_HOLDING_EMPTY_FLAG);
                    settle(3);
                end
                chk("irq_low", 0, {serial_irq_oe_n[c], serial_irq_outputs[c]});
            end
        end
        wb(1'b1, OFS_RUN, 3);
        for (int i = 0; i < 4; i++) begin
            lfsr = nxt(lfsr);
            @(posedge clk);
            tx_data_in <= lfsr[1:0];
            settle(1);
            chk("tx_run", {2'b11, lfsr[1:0]}, {serial_active, serial_tx_lines});
        end
        wb(1'b1, OFS_PWCTRL, 8'h10);
        settle(1);
        chk("pirq_oe", 0, printer_irq_oe_n);
        @(posedge clk);
        ack_go <= 1'b1;
        @(posedge clk);
        ack_go <= 1'b0;
        settle(7);
        chk("pirq_ack", 1, printer_irq_output);
        settle(8);
        chk("pirq_hold", 1, printer_irq_output);
        @(posedge clk);
        paper_out <= lfsr[3];
        settle(3);
        wb(1'b0, OFS_PSTAT, 0);
        chk("media", lfsr[3], rd[1]);
        settle(2);
        chk("pirq_clr", 0, printer_irq_output);
        @(posedge clk);
        {printer_irq_source_select, print_flag_in} <= 2'b11;
        settle(4);
        chk("pirq_flag", 1, printer_irq_output);
        @(posedge clk);
        print_flag_in <= 1'b0;
        settle(3);
        chk("pirq_flag0", 0, printer_irq_output);
        @(posedge clk);
        printer_irq_source_select <= 1'b0;
        wb(1'b1, OFS_PWCTRL, 8'h20);
        settle(1);
        chk("pirq_off", 1, printer_irq_oe_n);
        lfsr = nxt(lfsr);
        wb(1'b1, OFS_PWDATA, lfsr[7:0]);
        settle(1);
        chk("pd_out", {1'b0, lfsr[7:0]}, {pd_oe_n, pd});
        @(posedge clk);
        enhanced_port_select <= 1'b1;
        drive <= 1'b1;
        pdata <= lfsr[15:8];
        settle(4);
        chk("pd_dir_in", 1, pd_oe_n);
        wb(1'b0, OFS_PRDATA, 0);
        chk("pd_in", lfsr[15:8], rd);
        wb(1'b1, OFS_PWCTRL, 0);
        settle(1);
        chk("pd_dir_out", {1'b0, lfsr[7:0]}, {pd_oe_n, pd});
        wb(1'b0, 8'hfc, 0);
        chk("unmapped", 0, rd);
        end_sim();
    end
endmodule
